// ===== rtl/ucc_pkg.sv
// ucc_pkg: register map, field encodings and clock codes for the channel configuration block
// assumes a 32-bit axi4-lite slave with word-aligned registers
package ucc_pkg;
  localparam logic [7:0] ADDR_IMR    = 8'h00;
  localparam logic [7:0] ADDR_CTU    = 8'h04;
  localparam logic [7:0] ADDR_CTL    = 8'h08;
  localparam logic [7:0] ADDR_MRA    = 8'h0c;
  localparam logic [7:0] ADDR_MRB    = 8'h10;
  localparam logic [7:0] ADDR_CSA    = 8'h14;
  localparam logic [7:0] ADDR_CSB    = 8'h18;
  localparam logic [7:0] ADDR_ACR    = 8'h1c;
  localparam logic [7:0] ADDR_CMDA   = 8'h20;
  localparam logic [7:0] ADDR_CMDB   = 8'h24;
  localparam logic [7:0] ADDR_OPR    = 8'h28;
  localparam logic [7:0] ADDR_STAT   = 8'h2c;
  localparam logic [7:0] ADDR_CFGA   = 8'h30;
  localparam logic [7:0] ADDR_CFGB   = 8'h34;
  localparam logic [7:0] ADDR_ISR    = 8'h38;
  localparam logic [7:0] RST_BYTE    = 8'h00;
  localparam logic [2:0] CMD_SETPTR  = 3'h1;
  localparam logic [1:0] PAR_WITH    = 2'h0;
  localparam logic [1:0] PAR_FORCE   = 2'h1;
  localparam logic [1:0] PAR_NONE    = 2'h2;
  localparam logic [1:0] PAR_MDROP   = 2'h3;
  localparam logic [3:0] CLK_9600    = 4'hb;
  localparam logic [3:0] CLK_TIMER   = 4'hd;
  localparam logic [3:0] CLK_EXT16   = 4'he;
  localparam logic [3:0] CLK_EXT1    = 4'hf;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    UCC_NORMAL = 4'b0001,
    UCC_ECHO   = 4'b0010,
    UCC_LLOOP  = 4'b0100,
    UCC_RLOOP  = 4'b1000
  } ucc_mode_t;
endpackage : ucc_pkg

// ===== rtl/ucc_top.sv
// ucc_top: per-channel mode, clock-select and pin routing logic for a two-channel uart
// assumes axi4-lite master on aclk; serial cores sit outside and use the decoded controls
`timescale 1ns/1ps
`default_nettype none
module ucc_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [1:0]  serial_in,
  output logic [1:0]       serial_out,
  input  wire logic [1:0]  clear_to_send_in,
  input  wire logic        input_pin_three,
  input  wire logic        input_pin_four,
  input  wire logic        input_pin_five,
  input  wire logic        input_pin_six,
  input  wire logic [1:0]  core_tx_line,
  input  wire logic [1:0]  core_tx_idle,
  input  wire logic [1:0]  core_tx_enabled,
  input  wire logic [1:0]  core_tx_ready,
  input  wire logic [1:0]  core_tx_empty,
  input  wire logic [1:0]  core_rx_stop_seen,
  input  wire logic [1:0]  core_bit_tick,
  input  wire logic [7:0]  int_status,
  output logic [1:0]       core_rx_line,
  output logic [1:0]       rx_use_tx_clk,
  output logic [1:0]       tx_use_rx_clk,
  output logic [1:0]       tx_write_block,
  output logic [1:0]       rx_to_cpu_en,
  output logic [1:0]       rx_check_en,
  output logic [1:0]       tx_ready_flag,
  output logic [1:0]       tx_empty_flag,
  output logic [1:0]       tx_send_ok,
  output logic [1:0]       parity_on,
  output logic [1:0]       multidrop,
  output logic [1:0]       parity_odd,
  output logic [3:0]       data_bits_a,
  output logic [3:0]       data_bits_b,
  output logic [4:0]       stop_len_a,
  output logic [4:0]       stop_len_b,
  output logic [4:0]       baud_sel_rx_a,
  output logic [4:0]       baud_sel_tx_a,
  output logic [4:0]       baud_sel_rx_b,
  output logic [4:0]       baud_sel_tx_b,
  output logic [3:0]       ext_clk_sel,
  output logic [3:0]       ext_clk_1x,
  output logic [1:0]       output_pin_zero,
  output logic             irq
);
  // write channel capture
  logic       aw_held_r, w_held_r, bvalid_r, rvalid_r, w_strb0_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r, rdata_r;
  logic [1:0] bresp_r, rresp_r;
  logic [7:0] imr_r, ctu_r, ctl_r, csa_r, csb_r, acr_r, opr_r;
  logic [7:0] mr1_r [2];
  logic [7:0] mr2_r [2];
  logic [1:0] ptr_r;
  logic [1:0] in_s1_r, in_s2_r, cts_s1_r, cts_s2_r;
  logic [3:0] ext_s1_r, ext_s2_r;
  logic [1:0] hold_echo_r, rts_arm_r, cts_ok_r, idle_d_r;

  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready  = !w_held_r && !bvalid_r;
  wire       aw_fire = s_axi_awvalid && s_axi_awready;
  wire       w_fire  = s_axi_wvalid && s_axi_wready;
  wire       w_go    = (aw_held_r || aw_fire) && (w_held_r || w_fire) && !bvalid_r;
  wire [7:0] w_addr  = aw_held_r ? awaddr_r : s_axi_awaddr;
  wire [7:0] w_byte  = w_held_r ? wdata_r[7:0] : s_axi_wdata[7:0];
  wire       w_lane  = w_held_r ? w_strb0_r : s_axi_wstrb[0];
  wire       ar_fire = s_axi_arvalid && s_axi_arready;
  assign s_axi_arready = !rvalid_r;

  // register decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction
  wire w_mra = w_go && hit(w_addr, ucc_pkg::ADDR_MRA);
  wire w_mrb = w_go && hit(w_addr, ucc_pkg::ADDR_MRB);
  wire w_known = hit(w_addr, ucc_pkg::ADDR_IMR) || hit(w_addr, ucc_pkg::ADDR_CTU) ||
                 hit(w_addr, ucc_pkg::ADDR_CTL) || hit(w_addr, ucc_pkg::ADDR_MRA) ||
                 hit(w_addr, ucc_pkg::ADDR_MRB) || hit(w_addr, ucc_pkg::ADDR_CSA) ||
                 hit(w_addr, ucc_pkg::ADDR_CSB) || hit(w_addr, ucc_pkg::ADDR_ACR) ||
                 hit(w_addr, ucc_pkg::ADDR_CMDA) || hit(w_addr, ucc_pkg::ADDR_CMDB) ||
                 hit(w_addr, ucc_pkg::ADDR_OPR);
  wire r_mra = ar_fire && hit(s_axi_araddr, ucc_pkg::ADDR_MRA);
  wire r_mrb = ar_fire && hit(s_axi_araddr, ucc_pkg::ADDR_MRB);
  wire [1:0] mr_acc = {w_mrb || r_mrb, w_mra || r_mra};
  wire [1:0] setptr = {w_go && w_lane && hit(w_addr, ucc_pkg::ADDR_CMDB) && w_byte[6:4] == ucc_pkg::CMD_SETPTR,
                       w_go && w_lane && hit(w_addr, ucc_pkg::ADDR_CMDA) && w_byte[6:4] == ucc_pkg::CMD_SETPTR};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= ucc_pkg::RESP_OKAY;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h0000_0000;
      w_strb0_r <= 1'b0;
    end
    else
    begin
      if (aw_fire && !w_go)
        awaddr_r <= s_axi_awaddr;
      if (w_fire && !w_go)
      begin
        wdata_r   <= s_axi_wdata;
        w_strb0_r <= s_axi_wstrb[0];
      end
      aw_held_r <= w_go ? 1'b0 : (aw_held_r || aw_fire);
      w_held_r  <= w_go ? 1'b0 : (w_held_r || w_fire);
      if (w_go)
      begin
        bvalid_r <= 1'b1;
        bresp_r  <= w_known ? ucc_pkg::RESP_OKAY : ucc_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_r <= 1'b0;
    end
  end

  // configuration registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      imr_r <= ucc_pkg::RST_BYTE;
      ctu_r <= ucc_pkg::RST_BYTE;
      ctl_r <= ucc_pkg::RST_BYTE;
      csa_r <= ucc_pkg::RST_BYTE;
      csb_r <= ucc_pkg::RST_BYTE;
      acr_r <= ucc_pkg::RST_BYTE;
    end
    else if (w_go && w_lane)
    begin
      if (hit(w_addr, ucc_pkg::ADDR_IMR))
        imr_r <= w_byte;
      else if (hit(w_addr, ucc_pkg::ADDR_CTU))
        ctu_r <= w_byte;
      else if (hit(w_addr, ucc_pkg::ADDR_CTL))
        ctl_r <= w_byte;
      else if (hit(w_addr, ucc_pkg::ADDR_CSA))
        csa_r <= w_byte;
      else if (hit(w_addr, ucc_pkg::ADDR_CSB))
        csb_r <= w_byte;
      else if (hit(w_addr, ucc_pkg::ADDR_ACR))
        acr_r <= w_byte;
    end
  end

  // input synchronisers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      in_s1_r  <= 2'h3;
      in_s2_r  <= 2'h3;
      cts_s1_r <= 2'h3;
      cts_s2_r <= 2'h3;
      ext_s1_r <= 4'h0;
      ext_s2_r <= 4'h0;
    end
    else
    begin
      in_s1_r  <= serial_in;
      in_s2_r  <= in_s1_r;
      cts_s1_r <= clear_to_send_in;
      cts_s2_r <= cts_s1_r;
      ext_s1_r <= {input_pin_five, input_pin_six, input_pin_three, input_pin_four};
      ext_s2_r <= ext_s1_r;
    end
  end

  // baud select: {table set, 4-bit clock select code}
  function automatic logic [4:0] baud_code(input logic [3:0] c, input logic set2);
    baud_code = {set2, c};
  endfunction
  assign baud_sel_rx_a = baud_code(csa_r[7:4], acr_r[7]);
  assign baud_sel_tx_a = baud_code(csa_r[3:0], acr_r[7]);
  assign baud_sel_rx_b = baud_code(csb_r[7:4], acr_r[7]);
  assign baud_sel_tx_b = baud_code(csb_r[3:0], acr_r[7]);
  // ext order: rx a, tx a, rx b, tx b
  wire [15:0] codes = {csb_r[3:0], csb_r[7:4], csa_r[3:0], csa_r[7:4]};
  logic [1:0] opr_clr;

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_clk
      assign ext_clk_sel[g] = codes[4*g +: 4] == ucc_pkg::CLK_EXT16 ||
                              codes[4*g +: 4] == ucc_pkg::CLK_EXT1;
      assign ext_clk_1x[g] = codes[4*g +: 4] == ucc_pkg::CLK_EXT1;
    end
    for (g = 0; g < 2; g++)
    begin : g_ch
      ucc_pkg::ucc_mode_t mode;
      wire [7:0] m1 = mr1_r[g];
      wire [7:0] m2 = mr2_r[g];
      always_comb
      begin
        case (m2[7:6])
          2'b01:   mode = ucc_pkg::UCC_ECHO;
          2'b10:   mode = ucc_pkg::UCC_LLOOP;
          2'b11:   mode = ucc_pkg::UCC_RLOOP;
          default: mode = ucc_pkg::UCC_NORMAL;
        endcase
      end
      wire rl_m   = mode == ucc_pkg::UCC_RLOOP;
      wire echo_m = mode == ucc_pkg::UCC_ECHO || (hold_echo_r[g] && core_tx_enabled[g] && !rl_m);
      wire ll_m   = mode == ucc_pkg::UCC_LLOOP;
      wire resend = echo_m || rl_m;
      // stop just sampled in echo or remote loop keeps echo, while the transmitter is enabled, until the next bit tick
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          hold_echo_r[g] <= 1'b0;
        else if ((mode == ucc_pkg::UCC_ECHO || rl_m) && core_rx_stop_seen[g])
          hold_echo_r[g] <= 1'b1;
        else if (core_bit_tick[g])
          hold_echo_r[g] <= 1'b0;
      end
      assign serial_out[g]    = ll_m ? 1'b1 : (resend ? in_s2_r[g] : core_tx_line[g]);
      assign core_rx_line[g]  = ll_m ? core_tx_line[g] : in_s2_r[g];
      assign rx_use_tx_clk[g] = ll_m;
      assign tx_use_rx_clk[g] = resend;
      assign tx_write_block[g] = echo_m;
      assign tx_ready_flag[g] = !echo_m && core_tx_ready[g];
      assign tx_empty_flag[g] = !echo_m && core_tx_empty[g];
      assign rx_to_cpu_en[g]  = !rl_m;
      assign rx_check_en[g]   = !rl_m;
      assign parity_on[g]  = m1[4:3] == ucc_pkg::PAR_WITH || m1[4:3] == ucc_pkg::PAR_FORCE;
      assign multidrop[g]  = m1[4:3] == ucc_pkg::PAR_MDROP;
      assign parity_odd[g] = m1[2] && m1[4:3] != ucc_pkg::PAR_NONE;
      // clear-to-send latched while idle, held through a character
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          cts_ok_r[g] <= 1'b0;
        else if (core_tx_idle[g])
          cts_ok_r[g] <= !m2[4] || !cts_s2_r[g];
      end
      assign tx_send_ok[g] = cts_ok_r[g];
      // auto request-to-send release: one bit after drain with transmitter off
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          rts_arm_r[g] <= 1'b0;
          idle_d_r[g]  <= 1'b1;
        end
        else
        begin
          idle_d_r[g] <= core_tx_idle[g];
          if (!m2[5] || core_tx_enabled[g] || !core_tx_idle[g])
            rts_arm_r[g] <= 1'b0;
          else if (!idle_d_r[g])
            rts_arm_r[g] <= 1'b1;
        end
      end
      assign opr_clr[g] = rts_arm_r[g] && core_bit_tick[g];
    end
  endgenerate

  assign data_bits_a = 4'h5 + {2'b00, mr1_r[0][1:0]};
  assign data_bits_b = 4'h5 + {2'b00, mr1_r[1][1:0]};
  assign stop_len_a = ext_clk_1x[1] ? (mr2_r[0][3] ? 5'h10 : 5'h08) : {1'b0, mr2_r[0][3:0]} + 5'h01;
  assign stop_len_b = ext_clk_1x[3] ? (mr2_r[1][3] ? 5'h10 : 5'h08) : {1'b0, mr2_r[1][3:0]} + 5'h01;

  // mode registers and pointer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ptr_r <= 2'b00;
      opr_r <= ucc_pkg::RST_BYTE;
      for (int i = 0; i < 2; i++)
      begin
        mr1_r[i] <= ucc_pkg::RST_BYTE;
        mr2_r[i] <= ucc_pkg::RST_BYTE;
      end
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (setptr[i])
          ptr_r[i] <= 1'b0;
        else if (mr_acc[i] && !ptr_r[i])
          ptr_r[i] <= 1'b1;
        if (((i == 0) ? w_mra : w_mrb) && w_lane)
        begin
          if (ptr_r[i])
            mr2_r[i] <= w_byte;
          else
            mr1_r[i] <= w_byte;
        end
      end
      if (w_go && w_lane && hit(w_addr, ucc_pkg::ADDR_OPR))
        opr_r <= w_byte;
      else
        opr_r <= opr_r & ~{6'h00, opr_clr};
    end
  end
  assign output_pin_zero = ~opr_r[1:0];

  // read path
  wire [7:0] rd_byte =
    hit(s_axi_araddr, ucc_pkg::ADDR_MRA)  ? (ptr_r[0] ? mr2_r[0] : mr1_r[0]) :
    hit(s_axi_araddr, ucc_pkg::ADDR_MRB)  ? (ptr_r[1] ? mr2_r[1] : mr1_r[1]) :
    hit(s_axi_araddr, ucc_pkg::ADDR_OPR)  ? opr_r :
    hit(s_axi_araddr, ucc_pkg::ADDR_ACR)  ? acr_r :
    hit(s_axi_araddr, ucc_pkg::ADDR_STAT) ? {ptr_r, tx_empty_flag, tx_ready_flag, cts_ok_r} :
    hit(s_axi_araddr, ucc_pkg::ADDR_ISR)  ? int_status : 8'h00;
  wire rd_known = hit(s_axi_araddr, ucc_pkg::ADDR_MRA) || hit(s_axi_araddr, ucc_pkg::ADDR_MRB) ||
                  hit(s_axi_araddr, ucc_pkg::ADDR_OPR) || hit(s_axi_araddr, ucc_pkg::ADDR_ACR) ||
                  hit(s_axi_araddr, ucc_pkg::ADDR_STAT) || hit(s_axi_araddr, ucc_pkg::ADDR_ISR);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= ucc_pkg::RESP_OKAY;
    end
    else if (ar_fire)
    begin
      rvalid_r <= 1'b1;
      rdata_r  <= {24'h000000, rd_byte};
      rresp_r  <= rd_known ? ucc_pkg::RESP_OKAY : ucc_pkg::RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_r <= 1'b0;
  end
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata  = rdata_r;
  assign s_axi_rresp  = rresp_r;
  assign irq = |(int_status & imr_r);
endmodule // ucc_top
`default_nettype wire

// ===== dv/ucc_props.sv
// ucc_props: port-level checks for ucc_top
// assumes one aclk domain, synchronous active-low aresetn
`timescale 1ns/1ps
`default_nettype none
module ucc_props (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic [1:0] serial_in,
  input wire logic [1:0] serial_out,
  input wire logic [1:0] core_tx_line,
  input wire logic [1:0] core_tx_idle,
  input wire logic [1:0] rx_use_tx_clk,
  input wire logic [1:0] tx_use_rx_clk,
  input wire logic [1:0] rx_to_cpu_en,
  input wire logic [1:0] rx_check_en,
  input wire logic [1:0] tx_ready_flag,
  input wire logic [1:0] tx_empty_flag,
  input wire logic [1:0] tx_send_ok,
  input wire logic [3:0] data_bits_a,
  input wire logic [7:0] int_status,
  input wire logic       irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
  property p_r_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_r_ans: assert property (p_r_ans) else $error("no read answer");
  property p_norm; !tx_use_rx_clk[0] && !rx_use_tx_clk[0] |-> serial_out[0] == core_tx_line[0]; endproperty
  a_norm: assert property (p_norm) else $error("normal output wrong");
  property p_echo; tx_use_rx_clk[0] && $past(aresetn) && $past(aresetn, 2) |-> serial_out[0] == $past(serial_in[0], 2);
  endproperty
  a_echo: assert property (p_echo) else $error("echo output wrong");
  property p_local; rx_use_tx_clk[0] |-> serial_out[0]; endproperty
  a_local: assert property (p_local) else $error("local loop output low");
  property p_lcl_b; rx_use_tx_clk[1] |-> serial_out[1]; endproperty
  a_lcl_b: assert property (p_lcl_b) else $error("channel b loop output low");
  property p_flags; tx_use_rx_clk[0] && rx_to_cpu_en[0] |-> !tx_ready_flag[0] && !tx_empty_flag[0]; endproperty
  a_flags: assert property (p_flags) else $error("echo flags active");
  property p_rloop; tx_use_rx_clk[0] && !rx_to_cpu_en[0] |-> !rx_check_en[0]; endproperty
  a_rloop: assert property (p_rloop) else $error("remote loop checks on");
  property p_chars; data_bits_a >= 4'h5 && data_bits_a <= 4'h8; endproperty
  a_chars: assert property (p_chars) else $error("char length out of range");
  property p_cts; $past(aresetn) && !$past(core_tx_idle[0]) |-> $stable(tx_send_ok[0]); endproperty
  a_cts: assert property (p_cts) else $error("send gate moved mid character");
  property p_irq; irq |-> int_status != 8'h00; endproperty
  a_irq: assert property (p_irq) else $error("irq without cause");
  c_echo: cover property (tx_use_rx_clk[0] && rx_to_cpu_en[0]);
  c_rloop: cover property (tx_use_rx_clk[0] && !rx_to_cpu_en[0]);
  c_local: cover property (rx_use_tx_clk[0]);
  c_irq: cover property (irq);
endmodule // ucc_props
bind ucc_top ucc_props i_props (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .serial_in, .serial_out, .core_tx_line, .core_tx_idle, .rx_use_tx_clk, .tx_use_rx_clk,
  .rx_to_cpu_en, .rx_check_en, .tx_ready_flag, .tx_empty_flag, .tx_send_ok, .data_bits_a, .int_status, .irq);
`default_nettype wire

// ===== dv/ucc_station.sv
// ucc_station: remote serial station sending one frame on both lines
// assumes 8 clocks per bit; lines idle high between frames
`timescale 1ns/1ps
`default_nettype none
module ucc_station (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       send,
  output logic [1:0]      serial_in
);
  logic [9:0] sh_r;
  logic [6:0] cnt_r;
  always_ff @(posedge aclk)
  begin
    if (!aresetn) sh_r <= 10'h3ff;
    else if (cnt_r == 7'h00 && send) sh_r <= {1'b1, 8'h35, 1'b0};
    else if (cnt_r[2:0] == 3'h1) sh_r <= {1'b1, sh_r[9:1]};
    if (!aresetn) cnt_r <= 7'h00;
    else if (cnt_r == 7'h00 && send) cnt_r <= 7'h50;
    else if (cnt_r != 7'h00) cnt_r <= cnt_r - 7'h01;
  end
  assign serial_in = {2{sh_r[0]}};
endmodule // ucc_station
`default_nettype wire

// ===== dv/testbench.sv
// testbench: register-level scenarios for ucc_top
// assumes ucc_pkg, ucc_top, checker and station compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, send = 1'b0, tick_on = 1'b0, irq;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, int_status = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_data;
  logic [3:0]  s_axi_wstrb = 4'hf, data_bits_a, data_bits_b, ext_clk_sel, ext_clk_1x;
  logic [2:0]  tcnt = 3'h0;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rd_resp, wr_resp, serial_in, serial_out, clear_to_send_in = 2'h0;
  logic [1:0]  core_rx_stop_seen = 2'h0;
  logic [1:0]  core_tx_line = 2'h0, core_tx_idle = 2'h3, core_tx_enabled = 2'h0, core_tx_ready = 2'h3;
  logic [1:0]  core_tx_empty = 2'h3, core_bit_tick = 2'h0, core_rx_line, rx_use_tx_clk, tx_use_rx_clk;
  logic [1:0]  tx_write_block, rx_to_cpu_en, rx_check_en, tx_ready_flag, tx_empty_flag, tx_send_ok;
  logic [1:0]  parity_on, multidrop, parity_odd, output_pin_zero;
  logic [4:0]  stop_len_a, stop_len_b, baud_sel_rx_a, baud_sel_tx_a, baud_sel_rx_b, baud_sel_tx_b;
  logic [3:0]  mexp [4] = '{4'b0011, 4'b1011, 4'b0111, 4'b1000};
  int          n_mismatch = 0, tests_run = 0;
  ucc_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .serial_in, .serial_out,
    .clear_to_send_in, .input_pin_three(1'b0), .input_pin_four(1'b0), .input_pin_five(1'b0), .input_pin_six(1'b0),
    .core_tx_line, .core_tx_idle, .core_tx_enabled, .core_tx_ready, .core_tx_empty, .core_rx_stop_seen,
    .core_bit_tick, .int_status, .core_rx_line, .rx_use_tx_clk, .tx_use_rx_clk, .tx_write_block, .rx_to_cpu_en,
    .rx_check_en, .tx_ready_flag, .tx_empty_flag, .tx_send_ok, .parity_on, .multidrop, .parity_odd, .data_bits_a,
    .data_bits_b, .stop_len_a, .stop_len_b, .baud_sel_rx_a, .baud_sel_tx_a, .baud_sel_rx_b, .baud_sel_tx_b,
    .ext_clk_sel, .ext_clk_1x, .output_pin_zero, .irq);
  ucc_station i_station (.aclk, .aresetn, .send, .serial_in);
  always #4 aclk = ~aclk;
  always @(posedge aclk)
  begin
    tcnt <= tcnt + 3'h1;
    core_bit_tick <= {2{tick_on && tcnt == 3'h7}};
  end
  task automatic print_verdict;
    $display("mismatches %0d, comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1)
    begin
      n_mismatch++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic tmo(input logic done);
    if (!done)
    begin
      n_mismatch++;
      print_verdict();
    end
  endtask
  task automatic settle;
    @(posedge aclk);
    @(negedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int   n;
    logic ta = 1'b0, tw = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 60 && !(ta && tw); n++)
    begin
      @(negedge aclk);
      ta = ta || s_axi_awready === 1'b1;
      tw = tw || s_axi_wready === 1'b1;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    tmo(ta && tw);
    for (n = 0; n < 60 && s_axi_bvalid !== 1'b1; n++) @(negedge aclk);
    tmo(s_axi_bvalid === 1'b1);
    wr_resp = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    int   n;
    logic ta = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 60 && !ta; n++)
    begin
      @(negedge aclk);
      ta = s_axi_arready === 1'b1;
      @(posedge aclk);
    end
    tmo(ta);
    s_axi_arvalid <= 1'b0;
    for (n = 0; n < 60 && s_axi_rvalid !== 1'b1; n++) @(negedge aclk);
    tmo(s_axi_rvalid === 1'b1);
    rd_data = s_axi_rdata;
    rd_resp = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask
  task automatic s_pointer;
    rd(ucc_pkg::ADDR_STAT);
    chk(rd_data[7:6] === 2'b00, "pointers not at first after reset");
    for (int i = 0; i < 4; i++)
    begin
      wr(ucc_pkg::ADDR_CMDA, 8'h10);
      wr(ucc_pkg::ADDR_MRA, {3'b000, i[1:0], 1'b1, i[1:0]});
      chk(parity_on[0] === (i < 2) && multidrop[0] === (i == 3), "parity mode");
      chk(parity_odd[0] === (i != 2), "parity type");
      chk(data_bits_a === 4'(5 + i), "char length");
    end
    rd(ucc_pkg::ADDR_STAT);
    chk(rd_data[6] === 1'b1, "pointer did not advance");
    wr(ucc_pkg::ADDR_MRA, 8'h07);
    chk(stop_len_a === 5'd8, "stop length");
    rd(ucc_pkg::ADDR_MRA);
    chk(rd_data === 32'h07, "second mode readback");
    wr(ucc_pkg::ADDR_CMDA, 8'h10);
    rd(ucc_pkg::ADDR_MRA);
    chk(rd_data === 32'h1f, "first mode readback");
    rd(ucc_pkg::ADDR_STAT);
    chk(rd_data[6] === 1'b1, "read did not advance");
  endtask
  task automatic s_modes;
    int n;
    for (int m = 0; m < 4; m++)
    begin
      wr(ucc_pkg::ADDR_MRA, {m[1:0], 6'h00});
      chk({tx_use_rx_clk[0], rx_use_tx_clk[0], rx_to_cpu_en[0], rx_check_en[0]} === mexp[m], "mode");
      if (m == 0) chk(serial_out[0] === 1'b0 && core_rx_line[0] === 1'b1, "normal routing");
      if (m == 1) chk(!tx_ready_flag[0] && !tx_empty_flag[0] && tx_write_block[0], "echo tx side");
      if (m == 2) chk(serial_out[0] === 1'b1 && core_rx_line[0] === core_tx_line[0], "local loop");
      if (m[0])
      begin
        send <= 1'b1;
        settle();
        send <= 1'b0;
        for (n = 0; n < 40 && serial_out[0] !== 1'b0; n++) @(negedge aclk);
        chk(n < 40, "start bit not resent");
        repeat (90) @(posedge aclk);
      end
    end
    core_tx_enabled <= 2'h1;
    core_rx_stop_seen <= 2'h1;
    settle();
    core_rx_stop_seen <= 2'h0;
    wr(ucc_pkg::ADDR_MRA, 8'h00);
    chk(tx_use_rx_clk[0] === 1'b1 && tx_write_block[0] === 1'b1, "stop bit not finished");
    core_tx_enabled <= 2'h0;
    settle();
    chk(tx_use_rx_clk[0] === 1'b0, "echo kept with transmitter off");
  endtask
  task automatic s_rts;
    int n;
    wr(ucc_pkg::ADDR_MRA, 8'h20);
    core_tx_enabled <= 2'h3;
    wr(ucc_pkg::ADDR_OPR, 8'h01);
    core_tx_idle <= 2'h2;
    core_tx_empty <= 2'h2;
    tick_on <= 1'b1;
    chk(output_pin_zero[0] === 1'b0, "rts not asserted");
    core_tx_enabled <= 2'h2;
    repeat (30) settle();
    chk(output_pin_zero[0] === 1'b0, "rts dropped while sending");
    core_tx_idle <= 2'h3;
    core_tx_empty <= 2'h3;
    for (n = 0; n < 60 && output_pin_zero[0] !== 1'b1; n++) @(negedge aclk);
    chk(n > 1 && n < 60, "rts auto release");
    tick_on <= 1'b0;
  endtask
  task automatic s_cts;
    wr(ucc_pkg::ADDR_MRA, 8'h10);
    clear_to_send_in <= 2'h1;
    repeat (6) settle();
    chk(tx_send_ok[0] === 1'b0, "sent while cts negated");
    clear_to_send_in <= 2'h0;
    repeat (6) settle();
    chk(tx_send_ok[0] === 1'b1, "held while cts asserted");
    core_tx_idle <= 2'h2;
    clear_to_send_in <= 2'h1;
    repeat (6) settle();
    chk(tx_send_ok[0] === 1'b1, "mid character gate change");
    core_tx_idle <= 2'h3;
  endtask
  task automatic s_clocks;
    wr(ucc_pkg::ADDR_CSA, 8'hbb);
    wr(ucc_pkg::ADDR_MRA, 8'h08);
    chk(stop_len_a === 5'd9 && baud_sel_rx_a === 5'h0b, "16x stop length");
    wr(ucc_pkg::ADDR_CSA, 8'hbf);
    chk(stop_len_a === 5'd16 && baud_sel_tx_a === 5'h0f, "1x stop length");
    wr(ucc_pkg::ADDR_ACR, 8'h80);
    chk(baud_sel_rx_a === 5'h1b, "second table");
    wr(ucc_pkg::ADDR_CSB, 8'hde);
    chk(baud_sel_rx_b === 5'h1d && baud_sel_tx_b === 5'h1e, "channel b codes");
    chk(ext_clk_sel === 4'b1010 && ext_clk_1x === 4'b0010, "external clock routing");
    wr(ucc_pkg::ADDR_MRB, 8'h02);
    wr(ucc_pkg::ADDR_MRB, 8'h80);
    chk(data_bits_b === 4'd7 && rx_use_tx_clk[1] === 1'b1 && stop_len_b === 5'd1, "channel b modes");
  endtask
  task automatic s_irq;
    wr(ucc_pkg::ADDR_IMR, 8'h05);
    int_status <= 8'h02;
    settle();
    chk(irq === 1'b0, "masked cause raised irq");
    int_status <= 8'h04;
    settle();
    chk(irq === 1'b1, "enabled cause missing");
    rd(ucc_pkg::ADDR_ISR);
    chk(rd_data === 32'h04, "status readback");
    wr(ucc_pkg::ADDR_IMR, 8'h00);
    chk(irq === 1'b0, "irq after mask clear");
    rd(8'h3c);
    chk(rd_resp === ucc_pkg::RESP_SLVERR && rd_data === 32'h0, "unmapped read");
    wr(8'h3c, 8'h00);
    chk(wr_resp === ucc_pkg::RESP_SLVERR, "unmapped write");
  endtask
  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    s_pointer();
    s_modes();
    s_rts();
    s_cts();
    s_clocks();
    s_irq();
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
